/* src/pmr_cfg.svh */
// Register map, field positions, reset values and timing for the management registers
`ifndef PMR_CFG_SVH
`define PMR_CFG_SVH

`define PMR_AW              5
`define PMR_DW              16
`define PMR_PAGE_W          8

`define PMR_PAGE_COPPER     8'h00
`define PMR_PAGE_FIBER      8'h01

`define PMR_REG_FIB_CTL     5'h00
`define PMR_REG_FIB_MODE    5'h10
`define PMR_REG_CTL2        5'h14
`define PMR_REG_RX_ERR      5'h15
`define PMR_REG_PAGE        5'h16
`define PMR_REG_GLB_IRQ     5'h17
`define PMR_REG_IRQ_STS     5'h1A
`define PMR_REG_IRQ_MSK     5'h1B

`define PMR_CTL2_GAP_KEEP   6
`define PMR_CTL2_RST        16'h0020

`define PMR_FC_RESET        15
`define PMR_FC_LOOPBACK     14
`define PMR_FC_SPD_LSB      13
`define PMR_FC_SPD_MSB      6
`define PMR_SPD_MSB_RST     1'b1
`define PMR_SPD_LSB_RST     1'b0

`define PMR_MODE_RST        2'h0

`define PMR_IRQ_W           4
`define PMR_IRQ_RX_ERR      0
`define PMR_IRQ_CNT_SAT     1
`define PMR_IRQ_GAP_BREAK   2
`define PMR_IRQ_FRST_DONE   3

`define PMR_CNT_MAX         16'hFFFF

`define PMR_CLK_MHZ         50
`define PMR_FRST_NS         80
`define PMR_FRST_CYCLES     ((`PMR_FRST_NS * `PMR_CLK_MHZ + 999) / 1000)

`endif

/* src/pmr_pkg.sv */
// Types shared by the management register bank
package pmr_pkg;

   typedef enum logic [3:0] {
      PMR_MODE_100FX  = 4'h1,
      PMR_MODE_1000X  = 4'h2,
      PMR_MODE_LINK   = 4'h4,
      PMR_MODE_SW     = 4'h8
   } pmr_fmode_e;

   typedef enum logic [1:0] {
      PMR_FR_IDLE = 2'b01,
      PMR_FR_BUSY = 2'b10
   } pmr_frst_e;

   typedef logic [15:0] pmr_word_t;

endpackage

/* src/pmr_cnt_if.sv */
// Request and count signals between the register bank and its error counter
`timescale 1ns/1ns
`default_nettype none

interface pmr_cnt_if;
   logic        inc;
   logic        clr;
   logic [15:0] cnt;

   modport owner (input inc, input clr, output cnt);
   modport user  (output inc, output clr, input cnt);
endinterface

`default_nettype wire

/* src/pmr_err_cnt.sv */
// Saturating receive error counter with clear on read
`timescale 1ns/1ns
`default_nettype none

module pmr_err_cnt
   import pmr_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic core_clk_i,
   input  wire logic nrst_i,
   pmr_cnt_if.owner  c
);

   localparam logic [W-1:0] MAX = {W{1'b1}};

   logic [W-1:0] cnt_q;

   if (W != 16) begin : g_bad_width
      $error("pmr_err_cnt: the count register is 16 bits wide");
   end

   // Increment in the read cycle wins: the new count starts at one
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= '0;
      end else if (c.clr) begin
         cnt_q <= c.inc ? W'(1) : '0;
      end else if (c.inc && cnt_q != MAX) begin
         cnt_q <= cnt_q + W'(1);
      end
   end

   assign c.cnt = cnt_q;

   a_cnt_saturate: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (cnt_q == MAX && !c.clr) |=> cnt_q == MAX)
      else $error("error count left its ceiling");

   a_cnt_counts: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (c.inc && !c.clr && cnt_q != MAX) |=> cnt_q == $past(cnt_q) + W'(1))
      else $error("error count missed an event");

   a_cnt_read_clear: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (c.clr && !c.inc) |=> (cnt_q == '0) ##1 (cnt_q <= W'(1)))
      else $error("error count not cleared by read");

endmodule

`default_nettype wire

/* src/pmr_regs.sv */
// Management register bank: copper control, error count, page, interrupts, fiber control
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "pmr_cfg.svh"

// Overview of operation
// - Gap-break bit clear drops slow copper link on short gaps; set keeps it.
// - Each of four bits inverts transmit polarity of its own media pair.
// - Receive error count is 16 bits and sticks at its maximum.
// - False carrier and symbol errors both advance the count.
// - Eight-bit page number at a fixed address selects page; top byte reads zero.
// - Global interrupt bit 0 shows an active port interrupt; other bits zero.
// - Writing fiber reset resets fiber machines; bit clears itself when finished.
// - Fiber reset starts at once on the write.
// - Fiber loopback returns transmit data to receive and breaks the fiber link.
// - Loopback runs gigabit in gigabit mode and 100 Mbps in 100 Mbps mode.
// - Speed low bit reads 1 in mode 00 and 0 in mode 01.
// - Mode 10 low bit follows a 100 Mbps link; mode 11 it is writable.
// - Speed high bit 0 in mode 00, 1 in 01, gigabit link in 10, writable in 11.
module pmr_regs
   import pmr_pkg::*;
#(
   parameter int FRST_CYCLES = `PMR_FRST_CYCLES
) (
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   input  wire logic        sw_rst_i,
   input  wire logic [4:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   input  wire logic        false_carrier_i,
   input  wire logic        symbol_error_i,
   input  wire logic        short_ipg_i,
   input  wire logic        copper_slow_i,
   input  wire logic        link_at_100_i,
   input  wire logic        link_at_1000_i,
   output logic      [3:0]  tx_pol_inv_o,
   output logic             link_break_o,
   output logic             fiber_sm_rst_o,
   output logic             fiber_loopback_o,
   output logic             fiber_link_break_o,
   output logic             loopback_gig_o,
   output logic             irq_o
);

   if (FRST_CYCLES < 1 || FRST_CYCLES > 15) begin : g_bad_frst
      $error("pmr_regs: fiber reset length must be 1 to 15 cycles");
   end

   pmr_cnt_if cnt_if ();

   pmr_err_cnt #(
      .W (16)
   ) u_err_cnt (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .c          (cnt_if)
   );

   pmr_word_t                 ctl2_q;
   logic [`PMR_PAGE_W-1:0]    page_q;
   logic [1:0]                mode_q;
   logic                      lb_q;
   logic                      spd_msb_q;
   logic                      spd_lsb_q;
   logic [`PMR_IRQ_W-1:0]     sts_q;
   logic [`PMR_IRQ_W-1:0]     sts_d;
   logic [`PMR_IRQ_W-1:0]     msk_q;
   logic [`PMR_IRQ_W-1:0]     evt;
   pmr_frst_e                 frst_q;
   logic [3:0]                frst_cnt_q;
   logic                      frst_done;
   pmr_word_t                 rd_d;
   pmr_word_t                 rdata_q;
   logic                      break_q;
   logic                      gig_q;
   logic                      irq_q;
   pmr_fmode_e                fmode;
   logic                      spd_msb;
   logic                      spd_lsb;

   logic pg_cu;
   logic pg_fb;
   logic hit_ctl2;
   logic hit_cnt;
   logic hit_page;
   logic hit_glb;
   logic hit_sts;
   logic hit_msk;
   logic hit_fctl;
   logic hit_mode;
   logic frst_req;

   // Page register sits at one address on every page
   assign pg_cu    = page_q == `PMR_PAGE_COPPER;
   assign pg_fb    = page_q == `PMR_PAGE_FIBER;
   assign hit_page = reg_addr_i == `PMR_REG_PAGE;
   assign hit_ctl2 = pg_cu && reg_addr_i == `PMR_REG_CTL2;
   assign hit_cnt  = pg_cu && reg_addr_i == `PMR_REG_RX_ERR;
   assign hit_glb  = pg_cu && reg_addr_i == `PMR_REG_GLB_IRQ;
   assign hit_sts  = pg_cu && reg_addr_i == `PMR_REG_IRQ_STS;
   assign hit_msk  = pg_cu && reg_addr_i == `PMR_REG_IRQ_MSK;
   assign hit_fctl = pg_fb && reg_addr_i == `PMR_REG_FIB_CTL;
   assign hit_mode = pg_fb && reg_addr_i == `PMR_REG_FIB_MODE;
   assign frst_req = reg_wr_i && hit_fctl && reg_wdata_i[`PMR_FC_RESET];

   // Copper control two; reserved bits keep what the host writes
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctl2_q <= `PMR_CTL2_RST;
      end else if (reg_wr_i && hit_ctl2) begin
         ctl2_q <= reg_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_pol_inv_o <= 4'h0;
      end else begin
         tx_pol_inv_o <= (reg_wr_i && hit_ctl2) ? reg_wdata_i[3:0] : ctl2_q[3:0];
      end
   end

   // Short gaps only matter on 10 and 100 Mbps copper
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         break_q <= 1'b0;
      end else begin
         break_q <= short_ipg_i && copper_slow_i && !ctl2_q[`PMR_CTL2_GAP_KEEP];
      end
   end

   assign link_break_o = break_q;

   // Both error kinds feed one counter
   assign cnt_if.inc = false_carrier_i || symbol_error_i;
   assign cnt_if.clr = reg_rd_i && hit_cnt;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         page_q <= `PMR_PAGE_COPPER;
      end else if (reg_wr_i && hit_page) begin
         page_q <= reg_wdata_i[7:0];
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mode_q <= `PMR_MODE_RST;
      end else if (reg_wr_i && hit_mode) begin
         mode_q <= reg_wdata_i[1:0];
      end
   end

   always_comb begin
      unique case (mode_q)
         2'b00:   fmode = PMR_MODE_100FX;
         2'b01:   fmode = PMR_MODE_1000X;
         2'b10:   fmode = PMR_MODE_LINK;
         default: fmode = PMR_MODE_SW;
      endcase
   end

   // Pair 10 gigabit, 01 hundred, 00 ten
   always_comb begin
      unique case (fmode)
         PMR_MODE_100FX: begin
            spd_msb = 1'b0;
            spd_lsb = 1'b1;
         end
         PMR_MODE_1000X: begin
            spd_msb = 1'b1;
            spd_lsb = 1'b0;
         end
         PMR_MODE_LINK: begin
            spd_msb = link_at_1000_i;
            spd_lsb = link_at_100_i;
         end
         default: begin
            spd_msb = spd_msb_q;
            spd_lsb = spd_lsb_q;
         end
      endcase
   end

   // Stored speed bits only take writes in the host-owned mode
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         spd_msb_q <= `PMR_SPD_MSB_RST;
         spd_lsb_q <= `PMR_SPD_LSB_RST;
      end else if (reg_wr_i && hit_fctl && fmode == PMR_MODE_SW) begin
         spd_msb_q <= reg_wdata_i[`PMR_FC_SPD_MSB];
         spd_lsb_q <= reg_wdata_i[`PMR_FC_SPD_LSB];
      end
   end

   // Fiber reset acts in the write cycle itself, not at a later event
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         frst_q     <= PMR_FR_IDLE;
         frst_cnt_q <= 4'h0;
      end else begin
         unique case (frst_q)
            PMR_FR_IDLE: begin
               if (frst_req) begin
                  frst_q     <= PMR_FR_BUSY;
                  frst_cnt_q <= 4'h0;
               end
            end
            PMR_FR_BUSY: begin
               if (frst_req) begin
                  frst_cnt_q <= 4'h0;
               end else if (frst_cnt_q == 4'(FRST_CYCLES - 1)) begin
                  frst_q <= PMR_FR_IDLE;
               end else begin
                  frst_cnt_q <= frst_cnt_q + 4'h1;
               end
            end
            default: begin
               frst_q <= PMR_FR_IDLE;
            end
         endcase
      end
   end

   assign frst_done      = frst_q == PMR_FR_BUSY && !frst_req
                           && frst_cnt_q == 4'(FRST_CYCLES - 1);
   // One-hot busy code bit is the reset output itself
   assign fiber_sm_rst_o = frst_q[1];

   // A fiber or software reset drops loopback
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lb_q <= 1'b0;
      end else if (sw_rst_i || frst_req) begin
         lb_q <= 1'b0;
      end else if (reg_wr_i && hit_fctl) begin
         lb_q <= reg_wdata_i[`PMR_FC_LOOPBACK];
      end
   end

   assign fiber_loopback_o   = lb_q;
   assign fiber_link_break_o = lb_q;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gig_q <= 1'b0;
      end else begin
         gig_q <= spd_msb;
      end
   end

   assign loopback_gig_o = gig_q;

   // Sticky events; a new event beats the clear of a status read
   assign evt[`PMR_IRQ_RX_ERR]     = cnt_if.inc;
   assign evt[`PMR_IRQ_CNT_SAT]    = cnt_if.inc && !cnt_if.clr
                                     && cnt_if.cnt == `PMR_CNT_MAX - 16'h1;
   assign evt[`PMR_IRQ_GAP_BREAK]  = break_q;
   assign evt[`PMR_IRQ_FRST_DONE]  = frst_done;

   always_comb begin
      sts_d = (reg_rd_i && hit_sts) ? '0 : sts_q;
      sts_d = sts_d | evt;
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sts_q <= '0;
         msk_q <= '0;
      end else begin
         sts_q <= sts_d;
         if (reg_wr_i && hit_msk) begin
            msk_q <= reg_wdata_i[`PMR_IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(sts_q & msk_q);
      end
   end

   assign irq_o = irq_q;

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_d = '0;
      if (hit_page) begin
         rd_d[7:0] = page_q;
      end else if (hit_ctl2) begin
         rd_d = ctl2_q;
      end else if (hit_cnt) begin
         rd_d = cnt_if.cnt;
      end else if (hit_glb) begin
         rd_d[0] = irq_q;
      end else if (hit_sts) begin
         rd_d[`PMR_IRQ_W-1:0] = sts_q;
      end else if (hit_msk) begin
         rd_d[`PMR_IRQ_W-1:0] = msk_q;
      end else if (hit_fctl) begin
         rd_d[`PMR_FC_RESET]    = frst_q == PMR_FR_BUSY;
         rd_d[`PMR_FC_LOOPBACK] = lb_q;
         rd_d[`PMR_FC_SPD_LSB]  = spd_lsb;
         rd_d[`PMR_FC_SPD_MSB]  = spd_msb;
      end else if (hit_mode) begin
         rd_d[1:0] = mode_q;
      end
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= reg_rd_i ? rd_d : '0;
      end
   end

   assign reg_rdata_o = rdata_q;

   default clocking cb @(posedge core_clk_i);
   endclocking

   default disable iff (!nrst_i);

   a_gap_break_on: assert property (
      (short_ipg_i && copper_slow_i && !ctl2_q[`PMR_CTL2_GAP_KEEP]) |=> link_break_o)
      else $error("short gap did not break the link");
   a_gap_break_keep: assert property (
      (ctl2_q[`PMR_CTL2_GAP_KEEP] || !copper_slow_i) |=> !link_break_o)
      else $error("link broken while gap break is off");
   a_pair_polarity: assert property (
      (reg_wr_i && hit_ctl2) |=> tx_pol_inv_o == $past(reg_wdata_i[3:0]))
      else $error("pair polarity does not follow its bits");
   a_page_read: assert property (
      (reg_rd_i && hit_page && !reg_wr_i) |=> reg_rdata_o == {8'h00, $past(page_q)})
      else $error("page read wrong or upper byte set");
   a_irq_summary: assert property (
      (reg_rd_i && hit_glb) |=> reg_rdata_o == {15'h0000, $past(irq_q)})
      else $error("global interrupt bit wrong");
   a_frst_start: assert property (
      frst_req |=> fiber_sm_rst_o)
      else $error("fiber reset did not start at once");
   a_frst_ends: assert property (
      $rose(fiber_sm_rst_o) |-> ##[1:15] !fiber_sm_rst_o)
      else $error("fiber reset never cleared itself");
   a_lb_breaks: assert property (
      (reg_wr_i && hit_fctl && reg_wdata_i[`PMR_FC_LOOPBACK] && !frst_req && !sw_rst_i)
      |=> fiber_loopback_o && fiber_link_break_o)
      else $error("loopback did not break the fiber link");
   a_lb_speed: assert property (
      (mode_q == 2'b01 && $past(mode_q) == 2'b01) |-> loopback_gig_o)
      else $error("gigabit mode loopback not at gigabit");
   a_spd_fixed: assert property (
      (reg_rd_i && hit_fctl && mode_q == 2'b00)
      |=> reg_rdata_o[`PMR_FC_SPD_LSB] && !reg_rdata_o[`PMR_FC_SPD_MSB])
      else $error("speed bits wrong in hundred megabit mode");

endmodule

`default_nettype wire

/* verif/pmr_host.sv */
// Management host model driving the register port of the bank
`timescale 1ns/1ns
`default_nettype none
`include "pmr_cfg.svh"

module pmr_host (
   input  wire logic        core_clk_i,
   input  wire logic [15:0] rdata_i,
   output logic      [4:0]  addr_o,
   output logic      [15:0] wdata_o,
   output logic             wr_o,
   output logic             rd_o
);
   initial begin
      addr_o  = 5'h00;
      wdata_o = 16'h0000;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end

   // Idle bus shows inverted values so a stale word is never mistaken for a live one
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      if (a == `PMR_REG_CTL2) begin
         d = {8'h00, 1'b0, d[6], 2'b10, d[3:0]};
      end
      @(posedge core_clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge core_clk_i);
      wr_o    <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~d;
   endtask

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge core_clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge core_clk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a;
      @(posedge core_clk_i);
      d = rdata_i;
   endtask
endmodule

`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the management register bank
`timescale 1ns/1ns
`default_nettype none
`include "pmr_cfg.svh"

module tb_top;
   localparam int FRST = 6;
   logic        clk;
   logic        nrst;
   logic        sw_rst;
   logic        fc;
   logic        se;
   logic        sipg;
   logic        slow;
   logic        l100;
   logic        l1000;
   logic [4:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic [3:0]  pol;
   logic        lbrk;
   logic        fsr;
   logic        flb;
   logic        flbrk;
   logic        lgig;
   logic        irq;
   int          num_errors;
   int          checks;
   int          cyc;
   int          seed;
   int          m_mode;
   logic        m_msb;
   logic        m_lsb;
   logic        m_lb;

   pmr_regs #(.FRST_CYCLES(FRST)) i_dut (
      .core_clk_i(clk), .nrst_i(nrst), .sw_rst_i(sw_rst), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .false_carrier_i(fc), .symbol_error_i(se), .short_ipg_i(sipg),
      .copper_slow_i(slow), .link_at_100_i(l100), .link_at_1000_i(l1000),
      .tx_pol_inv_o(pol), .link_break_o(lbrk), .fiber_sm_rst_o(fsr),
      .fiber_loopback_o(flb), .fiber_link_break_o(flbrk), .loopback_gig_o(lgig),
      .irq_o(irq)
   );

   pmr_host i_host (
      .core_clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd)
   );

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rchk(input string nm, input logic [4:0] a, input logic [15:0] e);
      logic [15:0] d;
      i_host.rd(a, d);
      chk(nm, e, d);
   endtask

   // Expected fiber control word from the model state and live link levels
   function automatic logic [15:0] fib_exp(input logic busy);
      logic ms;
      logic ls;
      ms = (m_mode == 0) ? 1'b0 : (m_mode == 1) ? 1'b1 : (m_mode == 2) ? l1000 : m_msb;
      ls = (m_mode == 0) ? 1'b1 : (m_mode == 1) ? 1'b0 : (m_mode == 2) ? l100 : m_lsb;
      fib_exp = {busy, m_lb, ls, 6'h00, ms, 6'h00};
   endfunction

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         num_errors++;
         report_and_stop();
      end
   end

   initial begin
      logic [15:0] v;
      logic [15:0] r;
      int          n;
      logic        a;
      logic        b;
      {num_errors, checks, cyc, m_mode} = '0;
      seed = 85;
      {sw_rst, fc, se, sipg, slow, l100, l1000, m_lb, m_lsb} = '0;
      m_msb = 1'b1;
      nrst = 1'b0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      rchk("ctl2_rst", `PMR_REG_CTL2, `PMR_CTL2_RST);
      rchk("errcnt_rst", `PMR_REG_RX_ERR, 16'h0000);
      rchk("page_rst", `PMR_REG_PAGE, 16'h0000);
      rchk("glb_rst", `PMR_REG_GLB_IRQ, 16'h0000);
      #1 chk("rdata_idle", 16'h0000, rdata);
      for (int i = 0; i < 16; i++) begin
         v = $random(seed);
         v[3:0] = i;
         i_host.wr(`PMR_REG_CTL2, v);
         #1 chk("tx_pol", i, {12'h000, pol});
         rchk("ctl2", `PMR_REG_CTL2, {9'h000, v[6], 2'b10, v[3:0]});
      end
      // Third pass: gap bit clear, but gigabit copper must keep the link
      for (int k = 0; k < 3; k++) begin
         i_host.wr(`PMR_REG_CTL2, {9'h000, k[0], 6'h00});
         @(posedge clk);
         slow <= (k < 2);
         sipg <= 1'b1;
         @(posedge clk);
         sipg <= 1'b0;
         #1 chk("link_break", {15'h0000, k == 0}, {15'h0000, lbrk});
      end
      // Status holds the gap event; interrupt only once unmasked
      rchk("mask_rst", `PMR_REG_IRQ_MSK, 16'h0000);
      chk("irq_masked", 16'h0000, {15'h0000, irq});
      i_host.wr(`PMR_REG_IRQ_MSK, 16'h0004);
      rchk("glb_set", `PMR_REG_GLB_IRQ, 16'h0001);
      chk("irq_set", 16'h0001, {15'h0000, irq});
      rchk("sts_gap", `PMR_REG_IRQ_STS, 16'h0004);
      rchk("glb_clr", `PMR_REG_GLB_IRQ, 16'h0000);
      n = 0;
      for (int i = 0; i < 300; i++) begin
         a = $random(seed);
         b = $random(seed);
         @(posedge clk);
         fc <= a;
         se <= b;
         n += a | b;
      end
      @(posedge clk);
      fc <= 1'b0;
      se <= 1'b0;
      rchk("errcnt", `PMR_REG_RX_ERR, n);
      rchk("errcnt_clr", `PMR_REG_RX_ERR, 16'h0000);
      @(posedge clk);
      fc <= 1'b1;
      repeat (65540) @(posedge clk);
      fc <= 1'b0;
      rchk("errcnt_sat", `PMR_REG_RX_ERR, `PMR_CNT_MAX);
      rchk("errcnt_zero", `PMR_REG_RX_ERR, 16'h0000);
      rchk("sts_cnt", `PMR_REG_IRQ_STS, 16'h0003);
      i_host.wr(`PMR_REG_PAGE, 16'hAB01);
      rchk("page", `PMR_REG_PAGE, 16'h0001);
      rchk("wrong_page", `PMR_REG_CTL2, 16'h0000);
      for (int m = 0; m < 4; m++) begin
         r = $random(seed);
         @(posedge clk);
         l100 <= r[2];
         l1000 <= r[3];
         m_mode = m;
         i_host.wr(`PMR_REG_FIB_MODE, m);
         i_host.wr(`PMR_REG_FIB_CTL, {2'b01, r[0], 6'h00, r[1], 6'h00});
         if (m == 3) begin
            m_lsb = r[0];
            m_msb = r[1];
         end
         m_lb = 1'b1;
         rchk("fib_ctl", `PMR_REG_FIB_CTL, fib_exp(1'b0));
         chk("loopback", 16'h0003, {14'h0000, flb, flbrk});
         v = fib_exp(1'b0);
         chk("lb_speed", {15'h0000, v[6]}, {15'h0000, lgig});
         @(posedge clk);
         sw_rst <= 1'b1;
         @(posedge clk);
         sw_rst <= 1'b0;
         m_lb = 1'b0;
         #1 chk("lb_swrst", 16'h0000, {15'h0000, flb});
      end
      // Reset in the same write as loopback must win
      i_host.wr(`PMR_REG_FIB_CTL, 16'hC000 | fib_exp(1'b0));
      #1 chk("frst_now", 16'h0001, {15'h0000, fsr});
      chk("frst_no_lb", 16'h0000, {15'h0000, flb});
      n = 0;
      while (fsr === 1'b1 && n < 40) begin
         @(posedge clk);
         #1 n++;
      end
      chk("frst_len", FRST, n);
      i_host.wr(`PMR_REG_FIB_CTL, 16'h8000 | fib_exp(1'b0));
      rchk("frst_busy", `PMR_REG_FIB_CTL, fib_exp(1'b1));
      repeat (FRST) @(posedge clk);
      rchk("frst_done", `PMR_REG_FIB_CTL, fib_exp(1'b0));
      i_host.wr(`PMR_REG_PAGE, 16'h0000);
      rchk("sts_frst", `PMR_REG_IRQ_STS, 16'h0008);
      report_and_stop();
   end
endmodule

`default_nettype wire
